/* File: hw/cpsr_top.sv */
// file: sequential readout of a stored configuration bitstream
`timescale 1ns/1ps
//
// What this block does
// - each config_clock rising edge with a word loaded advances bit (serial) or address (parallel) only with select low, enable high.
// - enable/reset low holds counter reset and floats parallel_data_bus outputs.
// - enable/reset pin is open drain, driven low while internal reset active.
// - select high means standby, counter reset, all parallel_data_bus outputs floated.
// - serial mode sends one bit per clock on serial_data_out.
// - parallel mode sends one byte per clock on parallel_data_bus.
// - serial mode keeps upper seven data outputs always floated.
// - outputs valid once enabled, next word shortly after each rising edge.
// - cascade output drives next select; clocks and data shared in chain.
// - cascade output low only past terminal_count while enabled; else high.
module cpsr_top (
  // system clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_b_in,
  // link pins
  input  wire logic       config_clock_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       oe_reset_n_in,
  output logic            oe_reset_n_out,
  output logic            oe_reset_n_oe_out,
  input  wire logic       serial_mode_in,
  // data pins
  output logic            serial_data_out,
  output logic      [7:0] parallel_data_bus_out,
  output logic      [7:0] parallel_data_bus_oe_out,
  output logic            cascade_enable_out_n_out,
  // stored bitstream read port
  output logic      [9:0] mem_addr_out,
  output logic            mem_req_out,
  input  wire logic [7:0] mem_data_in
);
  ////////////////////////////////////////////////////////////////////////////
  logic       rst_meta_reg, rst_sync_reg;
  logic [1:0] clk_s_reg;
  logic [1:0] cs_s_reg;
  logic [1:0] oe_s_reg;
  logic [1:0] mode_s_reg;
  logic       clk_prev_reg;
  logic [9:0] addr_reg;
  logic       past_tc_reg;
  logic [2:0] bit_reg;
  logic [7:0] word_reg;
  logic       have_word_reg;
  logic       int_rst_reg;
  logic [1:0] hold_reg;

  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // two flip-flops on every pin input
  // the mode strap too: it may be moved while the part sits in standby
  always_ff @(posedge clk_sys_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      clk_s_reg    <= 2'h0;
      cs_s_reg     <= 2'h3;
      oe_s_reg     <= 2'h0;
      mode_s_reg   <= 2'h0;
      clk_prev_reg <= 1'b0;
    end else begin
      clk_s_reg    <= {clk_s_reg[0], config_clock_in};
      cs_s_reg     <= {cs_s_reg[0], chip_select_n_in};
      oe_s_reg     <= {oe_s_reg[0], oe_reset_n_in};
      mode_s_reg   <= {mode_s_reg[0], serial_mode_in};
      clk_prev_reg <= clk_s_reg[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  wire selected  = !cs_s_reg[1];
  wire enabled   = oe_s_reg[1];
  wire active    = selected && enabled;
  wire clk_rise  = clk_s_reg[1] && !clk_prev_reg;
  wire serial_mode = mode_s_reg[1];
  wire last_bit  = serial_mode ? (bit_reg == 3'h7) : 1'b1;
  // an edge with no word loaded is dropped rather than skipping a byte
  wire step      = active && clk_rise && have_word_reg;
  wire word_done = step && last_bit;
  wire take_word = !have_word_reg || word_done;
  wire at_tc     = (addr_reg == cpsr_pkg::TERMINAL_ADDR);

  // one increment shared by the fetch and the output address counters
  function automatic logic [9:0] addr_inc(input logic [9:0] a);
    return a + 10'h001;
  endfunction

  // fifo prefetches bytes so the link never waits on the store
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic       fetch_reg;
  logic [9:0] fetch_addr_reg;
  logic       fetch_done_reg;
  wire        fifo_pop = fifo_out_valid && take_word;
  // one read in flight at most, so the fifo's own ready already leaves room for it
  wire        fetch_go = fifo_in_ready && !fetch_done_reg && !fetch_reg && active;

  assign mem_addr_out = fetch_addr_reg;
  assign mem_req_out  = fetch_go;

  cpsr_fifo #(
    .WIDTH (cpsr_pkg::DATA_W),
    .DEPTH (cpsr_pkg::FIFO_DEPTH),
    .PTR_W (cpsr_pkg::FIFO_PTR_W)
  ) cpsr_fifo_inst (
    .clk_in        (clk_sys_in),
    .rst_b_in      (rst_sync_reg),
    .flush_in      (!active),
    .in_valid_in   (fetch_reg),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (mem_data_in),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (take_word),
    .out_data_out  (fifo_out_data)
  );

  always_ff @(posedge clk_sys_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      fetch_reg      <= 1'b0;
      fetch_addr_reg <= cpsr_pkg::ADDR_RESET;
      fetch_done_reg <= 1'b0;
    end else if (!active) begin
      fetch_reg      <= 1'b0;
      fetch_addr_reg <= cpsr_pkg::ADDR_RESET;
      fetch_done_reg <= 1'b0;
    end else begin
      fetch_reg <= fetch_go;
      if (fetch_go) begin
        fetch_addr_reg <= addr_inc(fetch_addr_reg);
        fetch_done_reg <= (fetch_addr_reg == cpsr_pkg::TERMINAL_ADDR);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address counter and output word
  always_ff @(posedge clk_sys_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      addr_reg      <= cpsr_pkg::ADDR_RESET;
      past_tc_reg   <= 1'b0;
      bit_reg       <= cpsr_pkg::BIT_RESET;
      word_reg      <= cpsr_pkg::DATA_RESET;
      have_word_reg <= 1'b0;
    end else if (!active) begin
      addr_reg      <= cpsr_pkg::ADDR_RESET;
      past_tc_reg   <= 1'b0;
      bit_reg       <= cpsr_pkg::BIT_RESET;
      have_word_reg <= 1'b0;
    end else begin
      if (step) begin
        bit_reg <= last_bit ? cpsr_pkg::BIT_RESET : bit_reg + 3'h1;
      end
      if (word_done) begin
        addr_reg <= addr_inc(addr_reg);
        if (at_tc) begin
          past_tc_reg <= 1'b1;
        end
      end
      if (fifo_pop) begin
        word_reg      <= fifo_out_data;
        have_word_reg <= 1'b1;
      end else if (word_done) begin
        have_word_reg <= 1'b0;
      end
    end
  end

  // internal reset pulls the shared open-drain line low for a short hold
  always_ff @(posedge clk_sys_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      int_rst_reg <= 1'b1;
      hold_reg    <= 2'h0;
    end else if (hold_reg != 2'(cpsr_pkg::RESET_HOLD_CYC)) begin
      hold_reg <= hold_reg + 2'h1;
    end else begin
      int_rst_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins are fed from flops; the extra cycle is far inside a link half period
  wire        cur_bit   = word_reg[3'h7 - bit_reg];
  wire  [7:0] lane_next = serial_mode ? {7'h00, cur_bit} : word_reg;
  wire        out_on    = active && have_word_reg;
  logic [7:0] lane_reg;
  logic       sbit_reg;
  logic       drive_reg;

  always_ff @(posedge clk_sys_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      lane_reg  <= cpsr_pkg::DATA_RESET;
      sbit_reg  <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      lane_reg  <= lane_next;
      sbit_reg  <= cur_bit;
      drive_reg <= out_on;
    end
  end

  assign oe_reset_n_out           = 1'b0;
  assign oe_reset_n_oe_out        = int_rst_reg || !rst_sync_reg;
  assign serial_data_out          = sbit_reg;
  assign parallel_data_bus_out    = lane_reg;
  // upper lanes float in serial mode regardless of stored byte
  assign parallel_data_bus_oe_out = !drive_reg ? 8'h00
                                  : (serial_mode ? 8'h01 : 8'hff);
  assign cascade_enable_out_n_out = !(active && past_tc_reg);
endmodule

/* File: hw/cpsr_pkg.sv */
// package: constants for the configuration memory sequential readout block
package cpsr_pkg;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned FIFO_DEPTH    = 32;
  localparam int unsigned FIFO_PTR_W    = 5;
  localparam logic [9:0]  TERMINAL_ADDR = 10'h3ff;
  localparam logic [9:0]  ADDR_RESET    = 10'h000;
  localparam logic [2:0]  BIT_RESET     = 3'h0;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam int unsigned RESET_HOLD_CYC = 2;
endpackage

/* File: hw/cpsr_fifo.sv */
// file: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module cpsr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned PTR_W = 5
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             flush_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_reg;
  logic [PTR_W-1:0] rd_reg;
  logic [PTR_W:0]   cnt_reg;
  wire              push = in_valid_in && in_ready_out;
  wire              pop  = out_valid_out && out_ready_in;

  assign in_ready_out  = (cnt_reg != (PTR_W+1)'(DEPTH));
  assign out_valid_out = (cnt_reg != '0);
  assign out_data_out  = mem_reg[rd_reg];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else if (flush_in) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == PTR_W'(DEPTH-1)) ? '0 : wr_reg + PTR_W'(1);
      end
      if (pop) begin
        rd_reg <= (rd_reg == PTR_W'(DEPTH-1)) ? '0 : rd_reg + PTR_W'(1);
      end
      cnt_reg <= cnt_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end
endmodule

/* File: bench/cpsr_top_assertions.sv */
// checker: port properties of the readout block
`timescale 1ns/1ps
module cpsr_top_assertions (
  // clock, reset and pins seen by the block
  input wire logic       clk_sys_in,
  input wire logic       rst_b_in,
  input wire logic       config_clock_in,
  input wire logic       chip_select_n_in,
  input wire logic       oe_reset_n_in,
  input wire logic       serial_mode_in,
  // pins driven by the block
  input wire logic       oe_reset_n_out,
  input wire logic       oe_reset_n_oe_out,
  input wire logic       cascade_enable_out_n_out,
  input wire logic [7:0] parallel_data_bus_out,
  input wire logic [7:0] parallel_data_bus_oe_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // six quiet samples cover sync plus the answer delay
  sequence link_quiet; !config_clock_in [*6]; endsequence
  sequence pull_release; oe_reset_n_oe_out ##[1:8] !oe_reset_n_oe_out; endsequence
  a_standby_float: assert property (chip_select_n_in |-> ##[1:5] parallel_data_bus_oe_out == 8'h00)
    else $error("driven in standby");
  a_reset_float: assert property (!oe_reset_n_in |-> ##[1:5] parallel_data_bus_oe_out == 8'h00)
    else $error("driven in reset");
  a_upper_float: assert property (serial_mode_in |-> parallel_data_bus_oe_out[7:1] == 7'h00)
    else $error("upper lanes driven");
  a_lane_code: assert property (parallel_data_bus_oe_out != 8'h00 |->
    parallel_data_bus_oe_out == (serial_mode_in ? 8'h01 : 8'hff))
    else $error("bad lane enables");
  a_cascade_idle: assert property ((chip_select_n_in || !oe_reset_n_in) |-> ##[1:5] cascade_enable_out_n_out)
    else $error("cascade low while idle");
  a_open_drain: assert property (disable iff (1'b0) (!rst_b_in ##1 !rst_b_in) |->
    oe_reset_n_oe_out && !oe_reset_n_out)
    else $error("line not pulled in reset");
  a_rst_pull: assert property ($rose(rst_b_in) |-> pull_release)
    else $error("reset pull missing");
  a_data_steady: assert property (link_quiet ##0 (parallel_data_bus_oe_out != 8'h00 &&
    $past(parallel_data_bus_oe_out) != 8'h00) |-> $stable(parallel_data_bus_out))
    else $error("data moved without edge");
endmodule

/* File: bench/cpsr_cfg_receiver.sv */
// model: configuration receiver acting as link clock master
`timescale 1ns/1ps
module cpsr_cfg_receiver (
  output logic            config_clock_out,
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] data_oe_in
);
  logic [7:0] seen = 8'h00;
  logic [7:0] cap [0:1023];
  initial config_clock_out = 1'b0;
  // clock stands low between frames; caller asks exactly the pulses needed
  task automatic clock_out(input int first, input int n);
    #13;
    for (int i = first; i < first + n; i++) begin
      #200 config_clock_out = 1'b1;
      // floating lanes show the inverse of the last level, no pull; sampled on the next edge
      seen = (data_in & data_oe_in) | (~seen & ~data_oe_in);
      cap[i % 1024] = seen;
      #200 config_clock_out = 1'b0;
    end
  endtask
endmodule

/* File: bench/tb_cpsr_top.sv */
// bench: testbench for the readout block
`timescale 1ns/1ps
module tb_cpsr_top;
  logic       clk_sys_in = 1'b0, rst_b_in = 1'b0, chip_select_n_in = 1'b1, serial_mode_in = 1'b0, oe_drv = 1'b1;
  logic       config_clock, oe_reset_n_out, oe_reset_n_oe_out, cascade_n, mem_req_out, sdo;
  logic [7:0] bus, bus_oe, mem_data = 8'h00;
  logic [9:0] mem_addr_out;
  int         err_count = 0, n_checks = 0;
  // open-drain line with pull-up
  wire        oe_line = oe_drv & ~(oe_reset_n_oe_out & ~oe_reset_n_out);
  always #25 clk_sys_in = ~clk_sys_in;
  function automatic logic [7:0] word(input int a); return a[7:0] ^ 8'ha5; endfunction
  always @(posedge clk_sys_in) if (mem_req_out) mem_data <= word(mem_addr_out);
  cpsr_top cpsr_top_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .config_clock_in(config_clock),
    .chip_select_n_in(chip_select_n_in), .oe_reset_n_in(oe_line), .oe_reset_n_out(oe_reset_n_out),
    .oe_reset_n_oe_out(oe_reset_n_oe_out), .serial_mode_in(serial_mode_in), .serial_data_out(sdo),
    .parallel_data_bus_out(bus), .parallel_data_bus_oe_out(bus_oe), .cascade_enable_out_n_out(cascade_n),
    .mem_addr_out(mem_addr_out), .mem_req_out(mem_req_out), .mem_data_in(mem_data));
  cpsr_cfg_receiver cpsr_cfg_receiver_inst (.config_clock_out(config_clock), .data_in(bus), .data_oe_in(bus_oe));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n); repeat (n) @(posedge clk_sys_in); #5; endtask
  task automatic wait_drive(); for (int i = 0; i < 40 && bus_oe === 8'h00; i++) settle(1); endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_idle();
    settle(10);
    chk(bus_oe, 8'h00); chk(cascade_n, 1'b1);
    chk(oe_line, 1'b1);
  endtask
  task automatic t_parallel();
    chip_select_n_in = 1'b0; wait_drive();
    chk(bus_oe, 8'hff);
    cpsr_cfg_receiver_inst.clock_out(0, 1023); settle(8);
    for (int i = 0; i < 3; i++) chk(cpsr_cfg_receiver_inst.cap[i], word(i));
    chk(cpsr_cfg_receiver_inst.cap[1022], word(1022)); chk(cascade_n, 1'b1);
    cpsr_cfg_receiver_inst.clock_out(1023, 1); settle(8);
    chk(cpsr_cfg_receiver_inst.cap[1023], word(1023)); chk(cascade_n, 1'b0);
    chip_select_n_in = 1'b1; settle(8);
    chk(bus_oe, 8'h00); chk(cascade_n, 1'b1);
  endtask
  task automatic t_serial();
    serial_mode_in = 1'b1; cpsr_cfg_receiver_inst.clock_out(0, 4); settle(1);
    chip_select_n_in = 1'b0; wait_drive();
    chk(bus_oe, 8'h01);
    cpsr_cfg_receiver_inst.clock_out(0, 16); settle(8);
    for (int i = 0; i < 16; i++) chk(cpsr_cfg_receiver_inst.cap[i][0], (word(i / 8) >> (7 - i % 8)) & 8'h01);
    chk(sdo, word(2) >> 7);
    oe_drv = 1'b0; settle(8);
    chk(bus_oe, 8'h00); chk(cascade_n, 1'b1);
    oe_drv = 1'b1; wait_drive();
    cpsr_cfg_receiver_inst.clock_out(0, 1); settle(8);
    chk(cpsr_cfg_receiver_inst.cap[0][0], word(0) >> 7);
  endtask
  initial begin
    settle(2);
    rst_b_in = 1'b1;
    t_idle(); t_parallel(); t_serial();
    give_verdict();
  end
  initial begin
    #1ms;
    err_count++;
    give_verdict();
  end
endmodule
bind cpsr_top cpsr_top_assertions cpsr_top_assertions_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
  .config_clock_in(config_clock_in), .chip_select_n_in(chip_select_n_in), .oe_reset_n_in(oe_reset_n_in),
  .serial_mode_in(serial_mode_in), .oe_reset_n_out(oe_reset_n_out), .oe_reset_n_oe_out(oe_reset_n_oe_out),
  .cascade_enable_out_n_out(cascade_enable_out_n_out), .parallel_data_bus_out(parallel_data_bus_out),
  .parallel_data_bus_oe_out(parallel_data_bus_oe_out));
